// ---- rtl/smc_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ---------------------------------------------------------------------
// register offsets (6-bit serial address)
// ---------------------------------------------------------------------
`define SMC_ADDR_W 6
`define SMC_DATA_W 24
`define SMC_OFF_THR 6'h30
`define SMC_OFF_MTX 6'h31
`define SMC_OFF_MODE 6'h32

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define SMC_RST_THR 9'h000
`define SMC_RST_MTX 17'h00000
`define SMC_RST_MODE 24'h000000

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define SMC_UPPER_MSB 8
`define SMC_UPPER_LSB 6
`define SMC_MIDDLE_MSB 5
`define SMC_MIDDLE_LSB 3
`define SMC_LOWER_MSB 2
`define SMC_LOWER_LSB 0
`define SMC_THR_USED_MSB 8
`define SMC_IRQ_MSB 16
`define SMC_IRQ_LSB 15
`define SMC_COM_MSB 14
`define SMC_COM_LSB 5
`define SMC_SIZE_MSB 4
`define SMC_SIZE_LSB 3
`define SMC_WIN_MSB 2
`define SMC_WIN_LSB 0
`define SMC_MTX_USED_MSB 16
`define SMC_MTX_RSVD_MSB 23
`define SMC_MTX_RSVD_LSB 17

// ---------------------------------------------------------------------
// serial frame layout
// ---------------------------------------------------------------------
`define SMC_FRAME_BITS 6'd32
`define SMC_HDR_LAST 6'd6
`define SMC_HDR_BITS 6'd7
`define SMC_CNT_MAX 6'h3f

// ---------------------------------------------------------------------
// timing: clock rate and matrix sample windows in microseconds
// ---------------------------------------------------------------------
`define SMC_CLK_MHZ 250
`define SMC_WIN_US_0 64
`define SMC_WIN_US_1 128
`define SMC_WIN_US_2 256
`define SMC_WIN_US_3 384
`define SMC_WIN_US_4 512
`define SMC_WIN_US_5 768
`define SMC_WIN_US_6 1024
`define SMC_WIN_US_7 1360
`define SMC_WIN_CYC_W 19

`endif

// ---- rtl/smc_pkg.sv ----
// types shared by the switch matrix configuration block
package smc_pkg;

    // -----------------------------------------------------------------
    // field encodings
    // -----------------------------------------------------------------
    // common threshold crossing interrupt selection
    typedef enum logic [1:0] {
        smc_irq_off,
        smc_irq_rise,
        smc_irq_fall,
        smc_irq_both
    } smc_irq_sel_t;

    // matrix arrangement
    typedef enum logic [1:0] {
        smc_mtx_none,
        smc_mtx_4x4,
        smc_mtx_5x5,
        smc_mtx_6x6
    } smc_mtx_size_t;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    // register access taken from the serial link
    typedef struct packed {
        logic wr;          // one-cycle write strobe
        logic [5:0] addr;  // register address of current frame
        logic [23:0] data; // write data
    } smc_req_t;

    // configuration handed to the detection engine
    typedef struct packed {
        logic [2:0] upper_sel;     // tri_level_upper_select
        logic [2:0] middle_sel;    // tri_level_middle_select
        logic [2:0] lower_sel;     // tri_level_lower_select
        smc_irq_sel_t irq_sel;     // common_cross_irq_sel
        logic [9:0] com_thr;       // common_threshold_value
        smc_mtx_size_t mtx_size;   // matrix arrangement
        logic [2:0] win_sel;       // matrix_sample_window code
        logic [23:0] detect_mode;  // detect_mode_bit_0..23, 1 = adc
    } smc_cfg_t;

endpackage

// ---- rtl/smc_spi_link.sv ----
// serial peripheral link: pin synchronisers, frame shifter, read return
`include "smc_consts.svh"
module smc_spi_link
    import smc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [23:0] rd_data,
    output smc_req_t req,
    output logic spi_miso
);

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [1:0] sclk_s; // stage 0 feeds stage 1 only
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_q; // delayed synchronised clock for edges
    logic cs_q;

    // two flops per pin before any logic looks at it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_s <= 2'b00;
            cs_s <= 2'b11;
            mosi_s <= 2'b00;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sclk_s <= {sclk_s[0], spi_sclk};
            cs_s <= {cs_s[0], spi_cs_n};
            mosi_s <= {mosi_s[0], spi_mosi};
            sclk_q <= sclk_s[1];
            cs_q <= cs_s[1];
        end
    end

    // -----------------------------------------------------------------
    // edge decode
    // -----------------------------------------------------------------
    wire active = ~cs_s[1];
    wire sclk_rise = active & sclk_s[1] & ~sclk_q;
    wire sclk_fall = active & ~sclk_s[1] & sclk_q;
    wire cs_fall = ~cs_s[1] & cs_q;
    wire cs_rise = cs_s[1] & ~cs_q;

    logic [5:0] bit_cnt;  // bits taken in this frame, saturating
    logic [31:0] shin;    // incoming frame
    logic [24:0] shout;   // read data plus trailing zero
    logic wflag;          // frame is a write
    logic load_pend;      // header done, fetch read data next cycle

    wire hdr_done = sclk_rise & (bit_cnt == `SMC_HDR_LAST);
    // a frame of the wrong length is dropped, not half written
    wire commit = cs_rise & wflag & (bit_cnt == `SMC_FRAME_BITS);
    wire [5:0] next_cnt = (bit_cnt == `SMC_CNT_MAX) ? bit_cnt
                                                    : bit_cnt + 6'd1;

    // -----------------------------------------------------------------
    // frame shifter
    // -----------------------------------------------------------------
    // sample on sclk rise, shift on fall (clock idles low)
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= 6'd0;
            shin <= 32'h00000000;
            shout <= 25'h0000000;
            wflag <= 1'b0;
            load_pend <= 1'b0;
            spi_miso <= 1'b0;
            req <= '0;
        end else begin
            req.wr <= commit;
            load_pend <= hdr_done;
            if (cs_fall) begin
                // new frame: restart the bit count, drop the write flag and clear miso
                bit_cnt <= 6'd0;
                wflag <= 1'b0;
                spi_miso <= 1'b0;
            end else if (sclk_rise) begin
                shin <= {shin[30:0], mosi_s[1]};
                bit_cnt <= next_cnt;
            end
            if (hdr_done) begin
                // header is write flag then six address bits
                wflag <= shin[5];
                req.addr <= {shin[4:0], mosi_s[1]};
            end
            if (load_pend) begin
                shout <= {rd_data, 1'b0};
            end else if (sclk_fall && bit_cnt >= `SMC_HDR_BITS) begin
                spi_miso <= shout[24];
                shout <= {shout[23:0], 1'b0};
            end
            if (commit) begin
                req.data <= shin[24:1];
            end
        end
    end

endmodule

// ---- rtl/smc_cfg_regs.sv ----
// configuration registers of the switch matrix and detection modes
//
// Behaviour
// - three 3-bit tri-level threshold selects
// - two-bit common crossing interrupt select
// - ten-bit common threshold in bits 14:5
// - two-bit matrix size select
// - window code maps to 64..1360 us
// - matrix bits 23:17 read zero
// - matrix control at 31h, resets zero
// - one detect mode bit per input
// - mode register at 32h, resets zero
`include "smc_consts.svh"
module smc_cfg_regs
    import smc_pkg::*;
#(
    // sample window lengths in ref_clk cycles; a bench may shorten them
    parameter logic [18:0] WIN_CYC [8] = '{
        19'(`SMC_WIN_US_0 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_1 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_2 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_3 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_4 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_5 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_6 * `SMC_CLK_MHZ),
        19'(`SMC_WIN_US_7 * `SMC_CLK_MHZ)
    }
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output smc_cfg_t cfg,
    output logic com_rise_en,
    output logic com_fall_en,
    output logic [2:0] matrix_dim,
    output logic [18:0] win_cycles
);

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    logic [8:0] thr_reg;    // threshold_map_cfg_two, used bits only
    logic [16:0] mtx_reg;   // matrix_control, below reserved bits
    logic [23:0] mode_reg;  // input_detect_mode
    smc_req_t req;          // access from the serial link
    logic [23:0] rd_data;   // read return to the link

    // -----------------------------------------------------------------
    // serial link
    // -----------------------------------------------------------------
    smc_spi_link u_link (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .rd_data(rd_data),
        .req(req),
        .spi_miso(spi_miso)
    );

    // -----------------------------------------------------------------
    // address decode, shared by write and read paths
    // -----------------------------------------------------------------
    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        hit = (a == o);
    endfunction

    wire sel_thr = hit(req.addr, `SMC_OFF_THR);
    wire sel_mtx = hit(req.addr, `SMC_OFF_MTX);
    wire sel_mode = hit(req.addr, `SMC_OFF_MODE);

    // next register values; writes to reserved bits are dropped
    wire [8:0] next_thr = (req.wr && sel_thr)
                          ? req.data[`SMC_THR_USED_MSB:0] : thr_reg;
    wire [16:0] next_mtx = (req.wr && sel_mtx)
                           ? req.data[`SMC_MTX_USED_MSB:0] : mtx_reg;
    wire [23:0] next_mode = (req.wr && sel_mode)
                            ? req.data : mode_reg;

    // read mux: unmapped addresses and reserved bits return zero
    assign rd_data = sel_thr ? {15'h0000, thr_reg}
                   : sel_mtx ? {7'h00, mtx_reg}
                   : sel_mode ? mode_reg
                   : 24'h000000;

    // -----------------------------------------------------------------
    // field decode toward the detection engine
    // -----------------------------------------------------------------
    wire [1:0] next_irq = next_mtx[`SMC_IRQ_MSB:`SMC_IRQ_LSB];
    wire [1:0] next_size = next_mtx[`SMC_SIZE_MSB:`SMC_SIZE_LSB];
    wire [2:0] next_win = next_mtx[`SMC_WIN_MSB:`SMC_WIN_LSB];
    // code 1 and 3 arm the rising crossing, 2 and 3 the falling one
    wire next_rise = (next_irq == smc_irq_rise)
                     || (next_irq == smc_irq_both);
    wire next_fall = (next_irq == smc_irq_fall)
                     || (next_irq == smc_irq_both);
    // matrix side length; zero means plain inputs
    wire [2:0] next_dim = (next_size == smc_mtx_4x4) ? 3'h4
                        : (next_size == smc_mtx_5x5) ? 3'h5
                        : (next_size == smc_mtx_6x6) ? 3'h6
                        : 3'h0;
    wire [18:0] next_wcyc = WIN_CYC[next_win];

    // -----------------------------------------------------------------
    // register update
    // -----------------------------------------------------------------
    // all configuration clears to zero: no matrix, no crossing irq,
    // shortest window, comparator detection on every input
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            thr_reg <= `SMC_RST_THR;
            mtx_reg <= `SMC_RST_MTX;
            mode_reg <= `SMC_RST_MODE;
        end else begin
            thr_reg <= next_thr;
            mtx_reg <= next_mtx;
            mode_reg <= next_mode;
        end
    end

    // decoded copies are flops so downstream timing stays clean
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            com_rise_en <= 1'b0;
            com_fall_en <= 1'b0;
            matrix_dim <= 3'h0;
            // code 0 window from the table, so a shortened table and
            // the decode agree from the very first edge
            win_cycles <= WIN_CYC[0];
        end else begin
            com_rise_en <= next_rise;
            com_fall_en <= next_fall;
            matrix_dim <= next_dim;
            win_cycles <= next_wcyc;
        end
    end

    // -----------------------------------------------------------------
    // configuration fields straight off the registers
    // -----------------------------------------------------------------
    // cfg bits come from the flops with no logic between
    assign cfg.upper_sel = thr_reg[`SMC_UPPER_MSB:`SMC_UPPER_LSB];
    assign cfg.middle_sel = thr_reg[`SMC_MIDDLE_MSB:`SMC_MIDDLE_LSB];
    assign cfg.lower_sel = thr_reg[`SMC_LOWER_MSB:`SMC_LOWER_LSB];
    assign cfg.irq_sel = smc_irq_sel_t'(mtx_reg[`SMC_IRQ_MSB:`SMC_IRQ_LSB]);
    assign cfg.com_thr = mtx_reg[`SMC_COM_MSB:`SMC_COM_LSB];
    assign cfg.mtx_size =
        smc_mtx_size_t'(mtx_reg[`SMC_SIZE_MSB:`SMC_SIZE_LSB]);
    assign cfg.win_sel = mtx_reg[`SMC_WIN_MSB:`SMC_WIN_LSB];
    // bit n of the mode word drives input n, bits 3 and 2 included
    assign cfg.detect_mode = mode_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    thr_write_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        req.wr && sel_thr |=> cfg.upper_sel == $past(req.data[8:6])
            && cfg.lower_sel == $past(req.data[2:0]))
        else $error("tri-level selects not taken from write");

    irq_decode_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        com_rise_en == (cfg.irq_sel == smc_irq_rise
                        || cfg.irq_sel == smc_irq_both)
        && com_fall_en == cfg.irq_sel[1])
        else $error("crossing interrupt enables disagree with select");

    com_thr_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        req.wr && sel_mtx |=> cfg.com_thr == $past(req.data[14:5]))
        else $error("common threshold not taken from bits 14:5");

    size_decode_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (cfg.mtx_size == smc_mtx_none) == (matrix_dim == 3'h0)
        && (cfg.mtx_size == smc_mtx_6x6) == (matrix_dim == 3'h6))
        else $error("matrix size decode wrong");

    window_map_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        win_cycles == WIN_CYC[cfg.win_sel])
        else $error("sample window length does not match code");

    rsvd_zero_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        sel_mtx |-> rd_data[23:17] == 7'h00)
        else $error("reserved matrix bits read nonzero");

    reset_clear_a: assert property (
        @(posedge ref_clk)
        $fell(sys_rst) |-> mtx_reg == 17'h00000 && matrix_dim == 3'h0
            && !com_rise_en && !com_fall_en)
        else $error("matrix control not clear after reset");

    mode_write_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        req.wr && sel_mode |=> cfg.detect_mode == $past(req.data)
            ##1 cfg.detect_mode == $past(cfg.detect_mode) || req.wr)
        else $error("detect mode not written or not held");

    mode_reset_a: assert property (
        @(posedge ref_clk)
        $fell(sys_rst) |-> cfg.detect_mode == 24'h000000)
        else $error("detect mode not comparator after reset");

    mode_lane_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        req.wr && sel_mode |=> cfg.detect_mode[3] == $past(req.data[3])
            && cfg.detect_mode[2] == $past(req.data[2]))
        else $error("mode bits 3 and 2 land on the wrong inputs");

endmodule

// ---- tb/test_smc_cfg_regs.sv ----
// self-checking bench for the switch matrix configuration registers
module test_smc_cfg_regs
    import smc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    // shortened sample windows keep the run short
    localparam logic [18:0] WIN [8] = '{19'h4, 19'h8, 19'h10, 19'h18,
        19'h20, 19'h30, 19'h40, 19'h55};
    localparam logic [2:0] DIM [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sclk = 1'b0; // serial clock idles low
    logic spi_cs_n = 1'b1; // deselected at start
    logic spi_mosi = 1'b0;
    logic spi_miso;
    smc_cfg_t cfg;
    logic com_rise_en;
    logic com_fall_en;
    logic [2:0] matrix_dim;
    logic [18:0] win_cycles;
    int fail_count = 0;
    int check_count = 0;
    logic [23:0] old, prev, exp, v;
    logic [1:0] irq, sz;
    logic [9:0] com;

    smc_cfg_regs #(.WIN_CYC(WIN)) i_smc_cfg_regs (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .cfg(cfg),
        .com_rise_en(com_rise_en),
        .com_fall_en(com_fall_en),
        .matrix_dim(matrix_dim),
        .win_cycles(win_cycles)
    );

    // 250 MHz reference clock
    always #2 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    // one compare, case equality so unknowns never match
    task automatic check(input string name, input logic [23:0] seen,
        input logic [23:0] expv);
        check_count++;
        if (seen !== expv) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, expv,
                seen);
        end
    endtask

    // verdict, reached from the main sequence or the watchdog
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // mode 0 frame, msb first; phases of 5 cycles beat the synchronisers
    task automatic spi_frame(input logic [31:0] word, input int nbits,
        output logic [23:0] rd);
        rd = 24'h0;
        spi_cs_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        for (int i = 0; i < nbits; i++) begin
            spi_sclk <= 1'b0;
            spi_mosi <= (i < 32) ? word[31 - i] : 1'b0;
            repeat (5) @(posedge ref_clk);
            // miso settled 3-4 cycles after the fall, sample before rise
            if (i >= 7 && i <= 30) begin
                rd[30 - i] = spi_miso;
            end
            spi_sclk <= 1'b1;
            repeat (5) @(posedge ref_clk);
        end
        spi_sclk <= 1'b0;
        repeat (5) @(posedge ref_clk);
        spi_cs_n <= 1'b1;
        // write lands about 4-5 cycles after deselect
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [23:0] d,
        output logic [23:0] o);
        spi_frame({1'b1, a, d, 1'b0}, 32, o);
    endtask

    task automatic reg_rd(input logic [5:0] a, output logic [23:0] o);
        spi_frame({1'b0, a, 24'h0, 1'b0}, 32, o);
    endtask

    // every output except spi_miso back at its reset value
    task automatic check_reset_outputs();
        check("cfg hi", 24'(cfg >> 26), 24'h0);
        check("cfg mid", 24'(cfg >> 24), 24'h0);
        check("cfg mode", cfg.detect_mode, 24'h0);
        check("rise en", 24'(com_rise_en), 24'h0);
        check("fall en", 24'(com_fall_en), 24'h0);
        check("dim", 24'(matrix_dim), 24'h0);
        check("window", 24'(win_cycles), 24'(WIN[0]));
    endtask

    // ------------------------------------------------------------------
    // watchdog: the whole sequence needs roughly 18600 cycles
    // ------------------------------------------------------------------
    initial begin
        repeat (80000) @(posedge ref_clk);
        fail_count++;
        $display("watchdog expired");
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // reset values through ports and serial reads
        check_reset_outputs();
        reg_rd(6'h31, v);
        check("mtx reset", v, 24'h0);
        reg_rd(6'h32, v);
        check("mode reset", v, 24'h0);
        reg_rd(6'h30, v);
        check("thr reset", v, 24'h0);
        $display("test reset values done");

        // every code in each tri-level select field
        prev = 24'h0;
        for (int n = 0; n < 8; n++) begin
            exp = {15'h0, 3'(n), 3'(7 - n), 3'(n ^ 5)};
            reg_wr(6'h30, exp, old);
            check("thr old", old, prev);
            check("upper", 24'(cfg.upper_sel), 24'(n));
            check("middle", 24'(cfg.middle_sel), 24'(7 - n));
            check("lower", 24'(cfg.lower_sel), 24'(n ^ 5));
            prev = exp;
        end
        reg_rd(6'h30, v);
        check("thr read", v, prev);
        // software keeps upper >= middle >= lower for the tri-level inputs
        reg_wr(6'h30, 24'h0001a2, old);
        check("thr before", old, prev);
        check("ordered up", 24'(cfg.upper_sel), 24'h6);
        check("ordered mid", 24'(cfg.middle_sel), 24'h4);
        check("ordered lo", 24'(cfg.lower_sel), 24'h2);
        $display("test threshold selects done");

        // matrix control: all irq, size and window codes, reserved set
        prev = 24'h0;
        for (int k = 0; k < 8; k++) begin
            irq = 2'(k);
            sz = 2'(k + 1);
            com = 10'(k * 73 + 1);
            exp = {7'h0, irq, com, sz, 3'(k)};
            reg_wr(6'h31, {7'h7f, exp[16:0]}, old);
            check("mtx old", old, prev);
            check("irq sel", 24'(cfg.irq_sel), 24'(irq));
            check("rise en", 24'(com_rise_en), 24'(irq[0]));
            check("fall en", 24'(com_fall_en), 24'(irq[1]));
            check("com thr", 24'(cfg.com_thr), 24'(com));
            check("size", 24'(cfg.mtx_size), 24'(sz));
            check("dim", 24'(matrix_dim), 24'(DIM[sz]));
            check("win sel", 24'(cfg.win_sel), 24'(k));
            check("window", 24'(win_cycles), 24'(WIN[k]));
            prev = exp;
        end
        // msb and lsb of the common threshold land at bits 14 and 5
        reg_wr(6'h31, 24'h004020, old);
        check("mtx last", old, prev);
        reg_rd(6'h31, v);
        check("com bits", v, 24'h004020);
        check("com val", 24'(cfg.com_thr), 24'h201);
        $display("test matrix control done");

        // walking one through the per-input mode bits
        prev = 24'h0;
        for (int n = 0; n < 24; n++) begin
            reg_wr(6'h32, 24'h1 << n, old);
            check("mode old", old, prev);
            check("mode", cfg.detect_mode, 24'h1 << n);
            prev = 24'h1 << n;
        end
        $display("test mode bits done");

        // frames of wrong length and unmapped address are refused
        spi_frame({1'b1, 6'h32, 24'hffffff, 1'b0}, 31, v);
        check("short", cfg.detect_mode, prev);
        spi_frame({1'b1, 6'h32, 24'hffffff, 1'b0}, 33, v);
        check("long", cfg.detect_mode, prev);
        reg_wr(6'h33, 24'hffffff, old);
        reg_rd(6'h33, v);
        check("unmapped", v, 24'h0);
        check("mode kept", cfg.detect_mode, prev);
        reg_rd(6'h31, v);
        check("mtx kept", v, 24'h004020);
        $display("test refused frames done");

        // 4x4 matrix with its row and column inputs left in comparator mode
        reg_wr(6'h32, 24'hffc30f, old);
        check("mode prev", old, prev);
        reg_wr(6'h31, 24'h000008, old);
        check("mtx prev", old, 24'h004020);
        check("4x4 dim", 24'(matrix_dim), 24'h4);
        check("4x4 lanes", cfg.detect_mode & 24'h003cf0, 24'h0);
        check("4x4 mode", cfg.detect_mode, 24'hffc30f);
        $display("test matrix setup done");

        // reset in mid-run clears everything again
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check_reset_outputs();
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reg_rd(6'h32, v);
        check("mode rst", v, 24'h0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
